// File: hdl/pmux_consts.svh
// offsets, field layout, reset values and sizes of the port 0 pin function multiplexer
// assumes byte addressing on the register port, one 32-bit word per register
`ifndef PMUX_CONSTS_SVH
`define PMUX_CONSTS_SVH
`define PMUX_OFF_SEL_LOW   32'he002c000
`define PMUX_OFF_SEL_HIGH  32'he002c004
`define PMUX_OFF_SEL_EXT   32'he002c014
`define PMUX_RST_SEL       32'h00000000
`define PMUX_PIN_N         23
`define PMUX_LOW_PINS      16
`define PMUX_FIELD_W       2
`define PMUX_CODE_GPIO     2'h0
`define PMUX_FN_N          45
`endif

// File: hdl/pmux_pkg.sv
// types shared by the pin function multiplexer and its bench
// assumes pmux_consts.svh is on the include path
`include "pmux_consts.svh"
package pmux_pkg;
	// one code per on-chip peripheral signal that can own a pin
	typedef enum logic [5:0] {
		FN_NONE      = 6'h00,
		FN_SP0_TXD   = 6'h01, FN_SP0_RXD   = 6'h02,
		FN_I2C_SCL   = 6'h03, FN_I2C_SDA   = 6'h04,
		FN_SPI_PORT_0_SCK  = 6'h05, FN_SPI_PORT_0_MISO = 6'h06, FN_SPI_PORT_0_MOSI = 6'h07, FN_SPI_PORT_0_SSEL = 6'h08,
		FN_SP1_TXD   = 6'h09, FN_SP1_RXD   = 6'h0a, FN_SP1_RTS   = 6'h0b, FN_SP1_CTS   = 6'h0c,
		FN_SP1_DSR   = 6'h0d, FN_SP1_DTR   = 6'h0e, FN_SP1_DCD   = 6'h0f, FN_SP1_RI    = 6'h10,
		FN_SPI_PORT_1_SCK  = 6'h11, FN_SPI_PORT_1_MISO = 6'h12, FN_SPI_PORT_1_MOSI = 6'h13, FN_SPI_PORT_1_SSEL = 6'h14,
		FN_PWM_1     = 6'h15, FN_PWM_2     = 6'h16, FN_PWM_3     = 6'h17, FN_PWM_4     = 6'h18,
		FN_PWM_5     = 6'h19, FN_PWM_6     = 6'h1a,
		FN_EIRQ_0    = 6'h1b, FN_EIRQ_1    = 6'h1c, FN_EIRQ_2    = 6'h1d, FN_EIRQ_3    = 6'h1e,
		FN_T0_CAP0   = 6'h1f, FN_T0_CAP1   = 6'h20, FN_T0_CAP2   = 6'h21,
		FN_T0_MAT0   = 6'h22, FN_T0_MAT1   = 6'h23, FN_T0_MAT2   = 6'h24,
		FN_T1_CAP0   = 6'h25, FN_T1_CAP1   = 6'h26, FN_T1_CAP2   = 6'h27, FN_T1_CAP3   = 6'h28,
		FN_T1_MAT0   = 6'h29, FN_T1_MAT1   = 6'h2a, FN_T1_MAT2   = 6'h2b, FN_T1_MAT3   = 6'h2c
	} pmux_fn_t;

	// how the direction of a pin owned by a peripheral is decided
	typedef enum logic [1:0] {
		DIR_IN     = 2'h0,
		DIR_OUT    = 2'h1,
		DIR_PERIPH = 2'h2
	} pmux_dir_t;

	typedef logic [`PMUX_FN_N-1:0]  pmux_fn_vec_t;
	typedef logic [`PMUX_PIN_N-1:0] pmux_pin_vec_t;

	// drive from the peripherals, indexed by pmux_fn_t
	typedef struct packed {
		pmux_fn_vec_t out;
		pmux_fn_vec_t oe;
	} pmux_periph_drv_t;

	// general-purpose I/O side of each pin
	typedef struct packed {
		pmux_pin_vec_t out;
		pmux_pin_vec_t dir;
	} pmux_gpio_drv_t;
endpackage

// File: hdl/pmux_top.sv
// port 0 pin function multiplexer: select registers, pin routing and direction
// assumes pins arrive asynchronously, peripherals and gpio logic run on i_ref_clk
// reserved select codes leave a pin undriven and cut off from every peripheral
//
// Local design decision: strobed register access.
`include "pmux_consts.svh"

// Function
// - each pin goes to gpio or to the peripheral its select field names.
// - gpio direction applies only under gpio; otherwise the function sets direction.
// - three read/write select registers at the three listed addresses.
// - low register pins 0,1,8,9: serial ports, pwm outputs, ext irq 0 and 3.
// - low register pins 2,3: i2c lines, timer 0 cap0/mat0, ext irq 1.
// - low register pins 4-7: spi port 0, timer 0 channels, pwm 2, ext irq 2.
// - low register pins 10-13: serial port 1 modem lines, timer 1 channels.
// - low register pins 14,15: serial port 1 dcd/ri, ext irq 1 and 2.
// - high register pin 16: ext irq 0, timer 0 match 2, capture 2.
// - high register pins 17-20: spi port 1, timer 1 channels, ext irq 3.
// - high register pins 21,22: pwm 5, timer 1 cap3, timer 0 cap0/mat0.
module pmux_top (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_reset_n,
	input  wire logic                      i_clk_en,
	input  wire logic [31:0]               i_addr,
	input  wire logic [31:0]               i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic      [31:0]               o_rdata,
	input  wire pmux_pkg::pmux_gpio_drv_t   i_gpio,
	input  wire pmux_pkg::pmux_periph_drv_t i_periph,
	input  wire logic [`PMUX_PIN_N-1:0]    i_pin_in,
	output logic      [`PMUX_PIN_N-1:0]    o_pin_out,
	output logic      [`PMUX_PIN_N-1:0]    o_pin_oe,
	output logic      [`PMUX_PIN_N-1:0]    o_gpio_in,
	output logic      [`PMUX_FN_N-1:0]     o_fn_in,
	output logic      [`PMUX_FN_N-1:0]     o_fn_mapped,
	output logic      [31:0]               o_sel_ext
);
	// map a pin and its two-bit code to the peripheral signal it selects
	function automatic pmux_pkg::pmux_fn_t pin_fn(input logic [4:0] pin, input logic [1:0] code);
		logic [6:0] key;
		key = {pin, code};
		pin_fn = pmux_pkg::FN_NONE;
		case (key)
			{5'h00, 2'h1}: pin_fn = pmux_pkg::FN_SP0_TXD;
			{5'h00, 2'h2}: pin_fn = pmux_pkg::FN_PWM_1;
			{5'h01, 2'h1}: pin_fn = pmux_pkg::FN_SP0_RXD;
			{5'h01, 2'h2}: pin_fn = pmux_pkg::FN_PWM_3;
			{5'h01, 2'h3}: pin_fn = pmux_pkg::FN_EIRQ_0;
			{5'h02, 2'h1}: pin_fn = pmux_pkg::FN_I2C_SCL;
			{5'h02, 2'h2}: pin_fn = pmux_pkg::FN_T0_CAP0;
			{5'h03, 2'h1}: pin_fn = pmux_pkg::FN_I2C_SDA;
			{5'h03, 2'h2}: pin_fn = pmux_pkg::FN_T0_MAT0;
			{5'h03, 2'h3}: pin_fn = pmux_pkg::FN_EIRQ_1;
			{5'h04, 2'h1}: pin_fn = pmux_pkg::FN_SPI_PORT_0_SCK;
			{5'h04, 2'h2}: pin_fn = pmux_pkg::FN_T0_CAP1;
			{5'h05, 2'h1}: pin_fn = pmux_pkg::FN_SPI_PORT_0_MISO;
			{5'h05, 2'h2}: pin_fn = pmux_pkg::FN_T0_MAT1;
			{5'h06, 2'h1}: pin_fn = pmux_pkg::FN_SPI_PORT_0_MOSI;
			{5'h06, 2'h2}: pin_fn = pmux_pkg::FN_T0_CAP2;
			{5'h07, 2'h1}: pin_fn = pmux_pkg::FN_SPI_PORT_0_SSEL;
			{5'h07, 2'h2}: pin_fn = pmux_pkg::FN_PWM_2;
			{5'h07, 2'h3}: pin_fn = pmux_pkg::FN_EIRQ_2;
			{5'h08, 2'h1}: pin_fn = pmux_pkg::FN_SP1_TXD;
			{5'h08, 2'h2}: pin_fn = pmux_pkg::FN_PWM_4;
			{5'h09, 2'h1}: pin_fn = pmux_pkg::FN_SP1_RXD;
			{5'h09, 2'h2}: pin_fn = pmux_pkg::FN_PWM_6;
			{5'h09, 2'h3}: pin_fn = pmux_pkg::FN_EIRQ_3;
			{5'h0a, 2'h1}: pin_fn = pmux_pkg::FN_SP1_RTS;
			{5'h0a, 2'h2}: pin_fn = pmux_pkg::FN_T1_CAP0;
			{5'h0b, 2'h1}: pin_fn = pmux_pkg::FN_SP1_CTS;
			{5'h0b, 2'h2}: pin_fn = pmux_pkg::FN_T1_CAP1;
			{5'h0c, 2'h1}: pin_fn = pmux_pkg::FN_SP1_DSR;
			{5'h0c, 2'h2}: pin_fn = pmux_pkg::FN_T1_MAT0;
			{5'h0d, 2'h1}: pin_fn = pmux_pkg::FN_SP1_DTR;
			{5'h0d, 2'h2}: pin_fn = pmux_pkg::FN_T1_MAT1;
			{5'h0e, 2'h1}: pin_fn = pmux_pkg::FN_SP1_DCD;
			{5'h0e, 2'h2}: pin_fn = pmux_pkg::FN_EIRQ_1;
			{5'h0f, 2'h1}: pin_fn = pmux_pkg::FN_SP1_RI;
			{5'h0f, 2'h2}: pin_fn = pmux_pkg::FN_EIRQ_2;
			{5'h10, 2'h1}: pin_fn = pmux_pkg::FN_EIRQ_0;
			{5'h10, 2'h2}: pin_fn = pmux_pkg::FN_T0_MAT2;
			{5'h10, 2'h3}: pin_fn = pmux_pkg::FN_T0_CAP2;
			{5'h11, 2'h1}: pin_fn = pmux_pkg::FN_T1_CAP2;
			{5'h11, 2'h2}: pin_fn = pmux_pkg::FN_SPI_PORT_1_SCK;
			{5'h11, 2'h3}: pin_fn = pmux_pkg::FN_T1_MAT2;
			{5'h12, 2'h1}: pin_fn = pmux_pkg::FN_T1_CAP3;
			{5'h12, 2'h2}: pin_fn = pmux_pkg::FN_SPI_PORT_1_MISO;
			{5'h12, 2'h3}: pin_fn = pmux_pkg::FN_T1_MAT3;
			{5'h13, 2'h1}: pin_fn = pmux_pkg::FN_T1_MAT2;
			{5'h13, 2'h2}: pin_fn = pmux_pkg::FN_SPI_PORT_1_MOSI;
			{5'h13, 2'h3}: pin_fn = pmux_pkg::FN_T1_CAP2;
			{5'h14, 2'h1}: pin_fn = pmux_pkg::FN_T1_MAT3;
			{5'h14, 2'h2}: pin_fn = pmux_pkg::FN_SPI_PORT_1_SSEL;
			{5'h14, 2'h3}: pin_fn = pmux_pkg::FN_EIRQ_3;
			{5'h15, 2'h1}: pin_fn = pmux_pkg::FN_PWM_5;
			{5'h15, 2'h3}: pin_fn = pmux_pkg::FN_T1_CAP3;
			{5'h16, 2'h2}: pin_fn = pmux_pkg::FN_T0_CAP0;
			{5'h16, 2'h3}: pin_fn = pmux_pkg::FN_T0_MAT0;
			// reserved codes listed so that they visibly map to nothing
			{5'h00, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h02, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h04, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h05, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h06, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h08, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0a, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0b, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0c, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0d, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0e, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h0f, 2'h3}: pin_fn = pmux_pkg::FN_NONE;
			{5'h15, 2'h2}: pin_fn = pmux_pkg::FN_NONE;
			{5'h16, 2'h1}: pin_fn = pmux_pkg::FN_NONE;
			default:       pin_fn = pmux_pkg::FN_NONE;
		endcase
	endfunction

	// direction class of each peripheral signal; bus-type lines follow the peripheral
	function automatic pmux_pkg::pmux_dir_t fn_dir(input pmux_pkg::pmux_fn_t fn);
		fn_dir = pmux_pkg::DIR_IN;
		case (fn)
			// driven only by the peripheral; the pin level still reaches o_fn_in
			pmux_pkg::FN_SP0_TXD,
			pmux_pkg::FN_SP1_TXD,
			pmux_pkg::FN_SP1_RTS,
			pmux_pkg::FN_SP1_DTR,
			pmux_pkg::FN_PWM_1,
			pmux_pkg::FN_PWM_2,
			pmux_pkg::FN_PWM_3,
			pmux_pkg::FN_PWM_4,
			pmux_pkg::FN_PWM_5,
			pmux_pkg::FN_PWM_6,
			pmux_pkg::FN_T0_MAT0,
			pmux_pkg::FN_T0_MAT1,
			pmux_pkg::FN_T0_MAT2,
			pmux_pkg::FN_T1_MAT0,
			pmux_pkg::FN_T1_MAT1,
			pmux_pkg::FN_T1_MAT2,
			pmux_pkg::FN_T1_MAT3: fn_dir = pmux_pkg::DIR_OUT;
			// peripheral decides per cycle: open-drain or master/slave turnaround
			pmux_pkg::FN_I2C_SCL,
			pmux_pkg::FN_I2C_SDA,
			pmux_pkg::FN_SPI_PORT_0_SCK,
			pmux_pkg::FN_SPI_PORT_0_MISO,
			pmux_pkg::FN_SPI_PORT_0_MOSI,
			pmux_pkg::FN_SPI_PORT_0_SSEL,
			pmux_pkg::FN_SPI_PORT_1_SCK,
			pmux_pkg::FN_SPI_PORT_1_MISO,
			pmux_pkg::FN_SPI_PORT_1_MOSI,
			pmux_pkg::FN_SPI_PORT_1_SSEL: fn_dir = pmux_pkg::DIR_PERIPH;
			default: fn_dir = pmux_pkg::DIR_IN;
		endcase
	endfunction

	// two-bit field of pin p out of the low or high select register
	function automatic logic [1:0] pin_code(input int p, input logic [31:0] lo, input logic [31:0] hi);
		logic [63:0] both;
		both = {hi, lo};
		pin_code = both[2*p +: `PMUX_FIELD_W];
	endfunction

	// register index of a byte address: 0 none, 1 low, 2 high, 3 ext
	// shared by the write and the read path so the two can never disagree
	function automatic logic [1:0] reg_sel(input logic [31:0] addr);
		reg_sel = 2'h0;
		if (addr == `PMUX_OFF_SEL_LOW) begin
			reg_sel = 2'h1;
		end else if (addr == `PMUX_OFF_SEL_HIGH) begin
			reg_sel = 2'h2;
		end else if (addr == `PMUX_OFF_SEL_EXT) begin
			reg_sel = 2'h3;
		end
	endfunction

	logic [31:0] sel_low_q, sel_low_d;
	logic [31:0] sel_high_q, sel_high_d;
	logic [31:0] sel_ext_q, sel_ext_d;
	logic [31:0] rdata_q, rdata_d;

	// select registers: writes to unmapped addresses are dropped
	always_comb begin
		sel_low_d  = sel_low_q;
		sel_high_d = sel_high_q;
		sel_ext_d  = sel_ext_q;
		if (i_wr && reg_sel(i_addr) == 2'h1) begin
			sel_low_d = i_wdata;
		end else if (i_wr && reg_sel(i_addr) == 2'h2) begin
			sel_high_d = i_wdata;
		end else if (i_wr && reg_sel(i_addr) == 2'h3) begin
			sel_ext_d = i_wdata;
		end
	end

	// select registers frozen while the clock enable is low, fields reset to gpio
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_low_q  <= `PMUX_RST_SEL;
			sel_high_q <= `PMUX_RST_SEL;
			sel_ext_q  <= `PMUX_RST_SEL;
		end else if (i_clk_en) begin
			sel_low_q  <= sel_low_d;
			sel_high_q <= sel_high_d;
			sel_ext_q  <= sel_ext_d;
		end
	end

	// read data one cycle after the strobe, zero otherwise so nothing stale lingers
	always_comb begin
		rdata_d = 32'h00000000;
		if (i_rd && reg_sel(i_addr) == 2'h1) begin
			rdata_d = sel_low_q;
		end else if (i_rd && reg_sel(i_addr) == 2'h2) begin
			rdata_d = sel_high_q;
		end else if (i_rd && reg_sel(i_addr) == 2'h3) begin
			rdata_d = sel_ext_q;
		end
	end

	// read data register, frozen by the clock enable as well
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= 32'h00000000;
		end else if (i_clk_en) begin
			rdata_q <= rdata_d;
		end
	end

	logic [`PMUX_PIN_N-1:0] pin_s1_q, pin_s2_q;
	logic [`PMUX_PIN_N-1:0] pin_out_q, pin_out_d;
	logic [`PMUX_PIN_N-1:0] pin_oe_q, pin_oe_d;
	logic [`PMUX_PIN_N-1:0] gpio_in_q, gpio_in_d;
	logic [`PMUX_FN_N-1:0]  fn_in_q, fn_in_d;
	logic [`PMUX_FN_N-1:0]  fn_map_q, fn_map_d;

	// routing of every pin; a signal mapped to two pins sees the or of both levels
	always_comb begin
		pmux_pkg::pmux_fn_t fn;
		logic [1:0]         code;
		fn        = pmux_pkg::FN_NONE;
		code      = `PMUX_CODE_GPIO;
		pin_out_d = '0;
		pin_oe_d  = '0;
		gpio_in_d = '0;
		fn_in_d   = '0;
		fn_map_d  = '0;
		for (int p = 0; p < `PMUX_PIN_N; p++) begin
			code = pin_code(p, sel_low_q, sel_high_q);
			fn   = pin_fn(5'(p), code);
			if (code == `PMUX_CODE_GPIO) begin
				pin_out_d[p] = i_gpio.out[p];
				pin_oe_d[p]  = i_gpio.dir[p];
				gpio_in_d[p] = pin_s2_q[p];
			end else if (fn != pmux_pkg::FN_NONE) begin
				pin_out_d[p]    = i_periph.out[fn];
				fn_in_d[fn]     = fn_in_d[fn] | pin_s2_q[p];
				fn_map_d[fn]    = 1'b1;
				case (fn_dir(fn))
					pmux_pkg::DIR_OUT:    pin_oe_d[p] = 1'b1;
					pmux_pkg::DIR_PERIPH: pin_oe_d[p] = i_periph.oe[fn];
					default:              pin_oe_d[p] = 1'b0;
				endcase
			end
			// a reserved code leaves the pin undriven and unconnected
		end
	end

	// two-stage synchroniser on the asynchronous pins; only the second stage is read
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else if (i_clk_en) begin
			pin_s1_q <= i_pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// registered pin and peripheral outputs
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_out_q <= '0;
			pin_oe_q  <= '0;
			gpio_in_q <= '0;
			fn_in_q   <= '0;
			fn_map_q  <= '0;
		end else if (i_clk_en) begin
			pin_out_q <= pin_out_d;
			pin_oe_q  <= pin_oe_d;
			gpio_in_q <= gpio_in_d;
			fn_in_q   <= fn_in_d;
			fn_map_q  <= fn_map_d;
		end
	end

	assign o_rdata     = rdata_q;
	assign o_pin_out   = pin_out_q;
	assign o_pin_oe    = pin_oe_q;
	assign o_gpio_in   = gpio_in_q;
	assign o_fn_in     = fn_in_q;
	assign o_fn_mapped = fn_map_q;
	assign o_sel_ext   = sel_ext_q;
endmodule

// File: verif/pmux_checker.sv
// concurrent checks on the pin mux ports
// assumes binding onto pmux_top, one clock domain
`include "pmux_consts.svh"
module pmux_checker (
	input wire logic                       i_ref_clk,
	input wire logic                       i_reset_n,
	input wire logic                       i_clk_en,
	input wire logic [31:0]                i_addr,
	input wire logic [31:0]                i_wdata,
	input wire logic                       i_wr,
	input wire logic                       i_rd,
	input wire logic [31:0]                o_rdata,
	input wire pmux_pkg::pmux_gpio_drv_t   i_gpio,
	input wire pmux_pkg::pmux_periph_drv_t i_periph,
	input wire logic [`PMUX_PIN_N-1:0]     o_pin_out,
	input wire logic [`PMUX_PIN_N-1:0]     o_pin_oe,
	input wire logic [`PMUX_PIN_N-1:0]     o_gpio_in,
	input wire logic [`PMUX_FN_N-1:0]      o_fn_mapped,
	input wire logic [31:0]                o_sel_ext
);
	logic [63:0]            sel_q;
	logic [63:0]            sel_d;
	logic [`PMUX_PIN_N-1:0] gmask;
	// shadow of both select words, so pin modes are known here
	always_comb begin
		sel_d = sel_q;
		if (i_clk_en && i_wr && i_addr == `PMUX_OFF_SEL_LOW) sel_d[31:0] = i_wdata;
		if (i_clk_en && i_wr && i_addr == `PMUX_OFF_SEL_HIGH) sel_d[63:32] = i_wdata;
		for (int p = 0; p < `PMUX_PIN_N; p++) gmask[p] = sel_q[2*p +: 2] == `PMUX_CODE_GPIO;
	end
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) sel_q <= 64'h0;
		else sel_q <= sel_d;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence wr_ext_s; i_clk_en && i_wr && i_addr == `PMUX_OFF_SEL_EXT; endsequence
	sequence rd_ext_s; i_clk_en && i_rd && i_addr == `PMUX_OFF_SEL_EXT; endsequence
	rdata_idle_a: assert property (i_clk_en && !i_rd |=> o_rdata == 32'h0)
		else $error("read data left standing");
	unmapped_rd_a: assert property (i_clk_en && i_rd && i_addr == 32'he002c008 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	ext_readback_a: assert property (wr_ext_s ##1 rd_ext_s |=> o_rdata == $past(i_wdata, 2))
		else $error("ext word read back wrong");
	sel_ext_a: assert property (wr_ext_s |=> o_sel_ext == $past(i_wdata))
		else $error("ext contents not updated");
	gpio_dir_a: assert property (i_clk_en |=> (o_pin_oe & $past(gmask)) == ($past(i_gpio.dir) & $past(gmask)))
		else $error("gpio pin direction wrong");
	gpio_out_a: assert property (i_clk_en |=> (o_pin_out & $past(gmask)) == ($past(i_gpio.out) & $past(gmask)))
		else $error("gpio pin value wrong");
	gpio_in_a: assert property (i_clk_en |=> (o_gpio_in & ~$past(gmask)) == 23'h0)
		else $error("gpio input seen on routed pin");
	txd_route_a: assert property (i_clk_en && sel_q[1:0] == 2'h1 |=> o_fn_mapped[pmux_pkg::FN_SP0_TXD]
		&& o_pin_oe[0] && o_pin_out[0] == $past(i_periph.out[pmux_pkg::FN_SP0_TXD]))
		else $error("transmit route wrong");
	rxd_dir_a: assert property (i_clk_en && sel_q[3:2] == 2'h1 |=> !o_pin_oe[1])
		else $error("receive pin driven");
	reserved_a: assert property (i_clk_en && sel_q[1:0] == 2'h3 |=> !o_pin_oe[0] && !o_pin_out[0])
		else $error("reserved code drives pin");
endmodule

// File: verif/pmux_far_model.sv
// far-side model: peripherals and gpio logic feeding the pin mux
// assumes the bench clock and active-low async reset
module pmux_far_model (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset_n,
	output pmux_pkg::pmux_gpio_drv_t   o_gpio,
	output pmux_pkg::pmux_periph_drv_t o_periph
);
	logic [22:0] gout_q;
	logic [44:0] pout_q;
	// values flip every cycle so a stale route cannot match
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gout_q <= 23'h2a5a5a;
			pout_q <= 45'h0a5a5a5a5a5a;
		end else begin
			gout_q <= ~gout_q;
			pout_q <= ~pout_q;
		end
	end
	// gpio asks for output on every pin; only gpio pins may obey
	assign o_gpio = {gout_q, 23'h7fffff};
	// all 45 enables held on, used only by routed i2c and spi lines
	assign o_periph = {pout_q, 45'h1fffffffffff};
endmodule

// File: verif/pmux_top_bench.sv
// self-checking bench for the pin mux: registers and routing
// assumes the design, checker and far-side model compile first
`include "pmux_consts.svh"
module pmux_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       i_ref_clk = 1'b0;
	logic                       i_reset_n = 1'b0;
	logic                       i_clk_en = 1'b1;
	logic                       i_wr = 1'b0;
	logic                       i_rd = 1'b0;
	logic [31:0]                i_addr = 32'h0;
	logic [31:0]                i_wdata = 32'h0;
	logic [`PMUX_PIN_N-1:0]     i_pin_in = 23'h0;
	logic [31:0]                o_rdata, o_sel_ext;
	logic [`PMUX_PIN_N-1:0]     o_pin_out, o_pin_oe, o_gpio_in;
	logic [`PMUX_FN_N-1:0]      o_fn_in, o_fn_mapped;
	pmux_pkg::pmux_gpio_drv_t   gpio;
	pmux_pkg::pmux_periph_drv_t periph;
	logic [31:0]                regs [3] = '{`PMUX_OFF_SEL_LOW, `PMUX_OFF_SEL_HIGH, `PMUX_OFF_SEL_EXT};
	int                         mismatches = 0;
	int                         num_checks = 0;
	// 40 MHz reference
	always #12.5 i_ref_clk = ~i_ref_clk;
	pmux_far_model pmux_far_model_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .o_gpio(gpio), .o_periph(periph));
	pmux_top pmux_top_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(gpio), .i_periph(periph),
		.i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_gpio_in(o_gpio_in),
		.o_fn_in(o_fn_in), .o_fn_mapped(o_fn_mapped), .o_sel_ext(o_sel_ext));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic test_reset;
		logic [31:0] d;
		foreach (regs[i]) begin
			rd_reg(regs[i], d);
			check("reset value", d, 32'h0);
		end
		check("gpio oe", o_pin_oe, 32'h007fffff);
		check("none mapped", 32'(|o_fn_mapped), 32'h0);
		// every pin is gpio after reset, so each level reaches the gpio side
		@(posedge i_ref_clk);
		i_pin_in <= 23'h2a5a5a;
		repeat (3) @(posedge i_ref_clk);
		#1 check("gpio in levels", o_gpio_in, 32'h002a5a5a);
		@(posedge i_ref_clk);
		i_pin_in <= 23'h0;
	endtask
	// a write while the clock enable is low must leave the register untouched
	task automatic test_clk_en;
		logic [31:0] d;
		@(posedge i_ref_clk);
		i_clk_en <= 1'b0;
		i_wr <= 1'b1;
		i_addr <= regs[2];
		i_wdata <= 32'h0000abcd;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_clk_en <= 1'b1;
		rd_reg(regs[2], d);
		check("frozen write", d, 32'h00000004);
	endtask
	task automatic test_regs;
		logic [31:0] d;
		logic [31:0] vals [3] = '{32'h55555555, 32'ha0000555, 32'h00000844};
		foreach (regs[i]) begin
			wr_reg(regs[i], vals[i]);
			rd_reg(regs[i], d);
			check("readback", d, vals[i]);
		end
		check("ext contents", o_sel_ext, vals[2]);
		wr_reg(32'he002c008, 32'hffffffff);
		rd_reg(32'he002c008, d);
		check("unmapped", d, 32'h0);
		rd_reg(regs[0], d);
		check("untouched", d, vals[0]);
		// write then read with no gap between strobes
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= regs[2];
		i_wdata <= 32'h00000004;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 check("ext back to back", o_rdata, 32'h00000004);
	endtask
	// entries: drives pin, pin, code, peripheral signal
	task automatic test_routes;
		int          pin;
		int          fn;
		logic [23:0] t [29] = '{24'h1_00_1_01, 24'h0_01_3_1b, 24'h1_08_2_18, 24'h0_09_3_1e, 24'h0_01_1_02,
			24'h1_02_1_03, 24'h1_03_2_22, 24'h0_03_3_1c, 24'h0_02_2_1f,
			24'h1_04_1_05, 24'h1_05_2_23, 24'h1_07_2_16, 24'h0_07_3_1d,
			24'h1_0a_1_0b, 24'h0_0b_2_26, 24'h1_0d_2_2a, 24'h0_0e_1_0f, 24'h0_0f_2_1d,
			24'h0_10_1_1b, 24'h1_10_2_24, 24'h0_10_3_21,
			24'h1_11_2_11, 24'h0_12_1_28, 24'h0_14_3_1e, 24'h1_13_1_2b,
			24'h1_15_1_19, 24'h0_15_3_28, 24'h0_16_2_1f, 24'h1_16_3_22};
		foreach (t[i]) begin
			pin = int'(t[i][19:12]);
			fn = int'(t[i][7:0]);
			wr_reg(pin < 16 ? regs[0] : regs[1], 32'(t[i][11:8]) << (2 * (pin % 16)));
			@(posedge i_ref_clk);
			#1 check("mapped", o_fn_mapped[fn], 32'h1);
			check("pin oe", o_pin_oe[pin], 32'(t[i][20]));
			if (t[i][20]) check("pin out", o_pin_out[pin], 32'(!periph.out[fn]));
			else begin
				@(posedge i_ref_clk);
				i_pin_in[pin] <= 1'b1;
				repeat (3) @(posedge i_ref_clk);
				#1 check("fn in", o_fn_in[fn], 32'h1);
				check("gpio in", o_gpio_in[pin], 32'h0);
				@(posedge i_ref_clk);
				i_pin_in[pin] <= 1'b0;
			end
		end
		wr_reg(regs[0], 32'h00000003);
		@(posedge i_ref_clk);
		#1 check("reserved oe", o_pin_oe[0], 32'h0);
		check("reserved out", o_pin_out[0], 32'h0);
	endtask
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		test_reset();
		test_regs();
		test_clk_en();
		test_routes();
		conclude();
	end
	// run needs under 10 us; cut a hang short well past that
	initial begin
		#50us;
		mismatches++;
		conclude();
	end
endmodule
bind pmux_top pmux_checker pmux_checker_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(i_gpio),
	.i_periph(i_periph), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_gpio_in(o_gpio_in),
	.o_fn_mapped(o_fn_mapped), .o_sel_ext(o_sel_ext));
